// ---- verilog/gpd_pkg.sv ----
package gpd_pkg;
    localparam int GPD_PINS = 8;
    localparam int GPD_AW = 8;
    localparam int GPD_DW = 32;
    // Register indices in the indirect space; byte address is index * 4
    localparam logic [7:0] GPD_IDX_DATA = 8'h2A;
    localparam logic [7:0] GPD_IDX_DIR = 8'h2B;
    localparam logic [7:0] GPD_IDX_STATUS = 8'h2D;
    localparam logic [1:0] GPD_WORD_LSB = 2'h0;
    localparam logic [7:0] GPD_DATA_RST = 8'h00;
    localparam logic [7:0] GPD_DIR_RST = 8'h00;
    localparam logic [GPD_DW-1:0] GPD_UNMAPPED = 32'h00000000;
    localparam logic [1:0] GPD_RESP_OK = 2'h0;
    localparam logic [1:0] GPD_RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [GPD_PINS-1:0] out;
        logic [GPD_PINS-1:0] oe;
    } gpd_pins_t;

    typedef enum logic [1:0] {
        GPD_SEL_NONE,
        GPD_SEL_DATA,
        GPD_SEL_DIR,
        GPD_SEL_STATUS
    } gpd_sel_t;

    function automatic gpd_sel_t gpd_decode(input logic [GPD_AW-1:0] a);
        if (a[1:0] != GPD_WORD_LSB) begin
            return GPD_SEL_NONE;
        end
        case (a[GPD_AW-1:2])
            GPD_IDX_DATA[5:0]: return GPD_SEL_DATA;
            GPD_IDX_DIR[5:0]: return GPD_SEL_DIR;
            GPD_IDX_STATUS[5:0]: return GPD_SEL_STATUS;
            default: return GPD_SEL_NONE;
        endcase
    endfunction
endpackage

// ---- verilog/gpd_pin_cell.sv ----
`timescale 1ns/1ps
module gpd_pin_cell
    import gpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [GPD_PINS-1:0] dir,
    input wire logic [GPD_PINS-1:0] level_out,
    input wire logic [GPD_PINS-1:0] pin_in,
    output gpd_pins_t drive,
    output logic [GPD_PINS-1:0] readback
);
    gpd_pins_t drive_nxt;
    logic [GPD_PINS-1:0] readback_nxt;

    // Bit n drives general pin n+1: bit 7 is the eighth pin
    assign drive_nxt.out = level_out & dir; // RULE_02 RULE_04
    assign drive_nxt.oe = dir; // RULE_05
    // Input pins read live level, outputs read back the stored level
    assign readback_nxt = (pin_in & ~dir) | (level_out & dir); // RULE_03

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            drive <= '0;
            readback <= '0;
        end else begin
            drive <= drive_nxt;
            readback <= readback_nxt;
        end
    end
endmodule

// ---- verilog/gpd_top.sv ----
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Function
// RULE_01: Pin data register sits at index 2Ah, eight bits, one per pin.
// RULE_02: Output-direction pins drive the written data bit level.
// RULE_03: Input-direction pins read back their present external level.
// RULE_04: Bit 7 maps to the eighth pin, bit 0 to the first.
// RULE_05: Direction bit 0 means input mode, 1 means output mode.
// RULE_06: Stored output data bits clear to zero on reset.
module gpd_top
    import gpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [GPD_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [GPD_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [GPD_DW-1:0] avs_readdata,
    output logic [1:0] avs_response,
    output logic avs_waitrequest,
    input wire logic [GPD_PINS-1:0] pin_i,
    output logic [GPD_PINS-1:0] pin_o,
    output logic [GPD_PINS-1:0] pin_oe
);
    logic [GPD_PINS-1:0] io_pin_data_r;
    logic [GPD_PINS-1:0] io_pin_dir_r;
    logic ack_r;
    logic [GPD_DW-1:0] avs_readdata_nxt;
    logic [1:0] avs_response_nxt;
    gpd_pins_t drive;
    logic [GPD_PINS-1:0] readback;

    wire gpd_sel_t sel = gpd_decode(avs_address);
    wire req = (avs_read | avs_write) & ~ack_r;
    // Write lands on the answer edge, where the master sees waitrequest low
    wire wr_ok = avs_write & ack_r & avs_byteenable[0];
    wire wr_data = wr_ok & (sel == GPD_SEL_DATA); // RULE_01
    wire wr_dir = wr_ok & (sel == GPD_SEL_DIR);
    wire [GPD_PINS-1:0] wdata = avs_writedata[GPD_PINS-1:0];

    // Status: pins currently driving, low byte
    always_comb begin
        avs_readdata_nxt = GPD_UNMAPPED;
        avs_response_nxt = GPD_RESP_OK;
        case (sel)
            GPD_SEL_DATA: avs_readdata_nxt[GPD_PINS-1:0] = readback; // RULE_03
            GPD_SEL_DIR: avs_readdata_nxt[GPD_PINS-1:0] = io_pin_dir_r;
            GPD_SEL_STATUS: avs_readdata_nxt[GPD_PINS-1:0] = drive.oe;
            default: avs_response_nxt = GPD_RESP_DECERR;
        endcase
    end

    // One wait state: answer lands with waitrequest low next cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= GPD_UNMAPPED;
            avs_response <= GPD_RESP_OK;
        end else begin
            ack_r <= req;
            avs_waitrequest <= ~req;
            if (req) begin
                avs_readdata <= avs_readdata_nxt;
                avs_response <= avs_response_nxt;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_pin_data_r <= GPD_DATA_RST; // RULE_06
            io_pin_dir_r <= GPD_DIR_RST;
        end else begin
            if (wr_data) begin
                io_pin_data_r <= wdata; // RULE_02
            end
            if (wr_dir) begin
                io_pin_dir_r <= wdata; // RULE_05
            end
        end
    end

    gpd_pin_cell u_cell (
        .clk_sys(clk_sys),
        .rst(rst),
        .dir(io_pin_dir_r),
        .level_out(io_pin_data_r),
        .pin_in(pin_i),
        .drive(drive),
        .readback(readback)
    );

    assign pin_o = drive.out;
    assign pin_oe = drive.oe;

    // Pin outputs lag the registers by one cycle through the pin cell
    a_out_follows_dir: assert property ( // RULE_02
        @(posedge clk_sys) disable iff (rst)
        wr_data |=> ##1 pin_o == $past(io_pin_data_r & io_pin_dir_r))
        else $error("pin level not driven from data");

    a_input_readback: assert property ( // RULE_03
        @(posedge clk_sys) disable iff (rst)
        ##1 ((readback & ~$past(io_pin_dir_r)) ==
            ($past(pin_i) & ~$past(io_pin_dir_r))))
        else $error("input pin readback wrong");

    a_oe_is_dir: assert property ( // RULE_05
        @(posedge clk_sys) disable iff (rst)
        ##1 pin_oe == $past(io_pin_dir_r))
        else $error("enable does not follow direction");

    a_data_write: assert property ( // RULE_01
        @(posedge clk_sys) disable iff (rst)
        wr_data |=> io_pin_data_r == $past(wdata))
        else $error("data write lost");

    a_bit_map: assert property ( // RULE_04
        @(posedge clk_sys) disable iff (rst)
        ##1 pin_o[GPD_PINS-1] == ($past(io_pin_data_r[GPD_PINS-1]) &
            $past(io_pin_dir_r[GPD_PINS-1])))
        else $error("bit seven not on eighth pin");

    a_bit_zero: assert property ( // RULE_04
        @(posedge clk_sys) disable iff (rst)
        ##1 pin_o[0] == ($past(io_pin_data_r[0]) & $past(io_pin_dir_r[0])))
        else $error("bit zero not on first pin");

    // Reset is asynchronous, so these checks carry no disable
    a_reset_low: assert property ( // RULE_06
        @(posedge clk_sys) $fell(rst) |-> io_pin_data_r == GPD_DATA_RST)
        else $error("data not cleared by reset");

    a_reset_pins: assert property ( // RULE_06
        @(posedge clk_sys)
        $fell(rst) |-> io_pin_dir_r == GPD_DIR_RST && pin_o == '0)
        else $error("pins not idle after reset");

    a_wait_one: assert property (
        @(posedge clk_sys) disable iff (rst)
        req |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest timing wrong");

    a_wait_idle: assert property (
        @(posedge clk_sys) disable iff (rst)
        !avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without request");

    a_answer_once: assert property (
        @(posedge clk_sys) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");

    a_ack_pulse: assert property (
        @(posedge clk_sys) disable iff (rst)
        ack_r |=> !ack_r)
        else $error("request taken twice");

    a_no_drive_in: assert property ( // RULE_05
        @(posedge clk_sys) disable iff (rst)
        ((pin_o & ~pin_oe) == '0))
        else $error("input pin driven");

    a_dir_write: assert property ( // RULE_05
        @(posedge clk_sys) disable iff (rst)
        wr_dir |=> io_pin_dir_r == $past(wdata))
        else $error("direction write lost");

    a_data_hold: assert property ( // RULE_02
        @(posedge clk_sys) disable iff (rst)
        !wr_data |=> io_pin_data_r == $past(io_pin_data_r))
        else $error("data changed without write");

    a_dir_hold: assert property ( // RULE_05
        @(posedge clk_sys) disable iff (rst)
        !wr_dir |=> io_pin_dir_r == $past(io_pin_dir_r))
        else $error("direction changed without write");

    // A write without byte 0 is answered but must leave state alone
    a_be_refused: assert property ( // RULE_02
        @(posedge clk_sys) disable iff (rst)
        avs_write && !avs_byteenable[0] |=>
            io_pin_data_r == $past(io_pin_data_r))
        else $error("masked write changed data");

    a_resp_decerr: assert property ( // RULE_01
        @(posedge clk_sys) disable iff (rst)
        req && sel == GPD_SEL_NONE |=> avs_response == GPD_RESP_DECERR)
        else $error("unmapped access not refused");

    a_resp_ok: assert property ( // RULE_01
        @(posedge clk_sys) disable iff (rst)
        req && sel != GPD_SEL_NONE |=> avs_response == GPD_RESP_OK)
        else $error("mapped access refused");

    a_read_data: assert property ( // RULE_03
        @(posedge clk_sys) disable iff (rst)
        req && sel == GPD_SEL_DATA |=>
            avs_readdata[GPD_PINS-1:0] == $past(readback))
        else $error("data read wrong");

    a_oe_status: assert property (
        @(posedge clk_sys) disable iff (rst)
        req && sel == GPD_SEL_STATUS |=>
            avs_readdata[GPD_PINS-1:0] == $past(pin_oe))
        else $error("status read wrong");

    a_upper_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        !avs_waitrequest |-> avs_readdata[GPD_DW-1:GPD_PINS] == '0)
        else $error("upper read bits not zero");

    // Read data must stand until the next request is taken
    a_readdata_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        !req |=> $stable(avs_readdata))
        else $error("read data moved while idle");
endmodule

// ---- test/gpd_ext_model.sv ----
`timescale 1ns/1ps
module gpd_ext_model
    import gpd_pkg::*;
(
    input wire logic [GPD_PINS-1:0] pin_o,
    input wire logic [GPD_PINS-1:0] pin_oe,
    input wire logic [GPD_PINS-1:0] ext,
    output logic [GPD_PINS-1:0] pin_i
);
    // Driven pins show the device level, the rest our own source
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import gpd_pkg::*;
;
    logic clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [7:0] avs_address = 0, ext = 0, pin_i, pin_o, pin_oe, d, r;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [1:0] avs_response;
    logic [3:0] be = 4'hF;
    logic avs_waitrequest;
    logic [33:0] exp_q[$];
    int mismatches = 0, n_compared = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    gpd_top gpd_top_i(.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(be),
        .avs_readdata(avs_readdata), .avs_response(avs_response),
        .avs_waitrequest(avs_waitrequest), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe));
    gpd_ext_model gpd_ext_model_i(.pin_o(pin_o), .pin_oe(pin_oe),
        .ext(ext), .pin_i(pin_i));
    task automatic check(input string nm, input logic [33:0] got,
        input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Request held until waitrequest is seen low, then released
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, v};
        do @(posedge clk_sys); while (avs_waitrequest);
        avs_write <= 0;
        avs_read <= 0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        acc(0, a, 8'h00);
    endtask
    task automatic pins(input logic [7:0] o, input logic [7:0] oe);
        repeat (2) @(posedge clk_sys);
        check("pin_o", pin_o, o);
        check("pin_oe", pin_oe, oe);
    endtask
    always @(posedge clk_sys)
        if (avs_read && !avs_waitrequest && exp_q.size() > 0)
            check("read", {avs_response, avs_readdata}, exp_q.pop_front());
    always @(posedge clk_sys)
        if (++cyc == 3000) begin
            mismatches++;
            wrap_up();
        end
    initial begin
        void'($urandom(44809));
        repeat (20) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        ext <= $urandom;
        rd(8'hAC, 34'h0);
        acc(1, 8'hAC, 8'hFF);
        rd(8'hA8, 34'h0);
        pins(8'h00, 8'hFF);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            acc(1, 8'hA8, 8'h01 << i);
            pins(8'h01 << i, 8'hFF);
            rd(8'hA8, {26'h0, 8'h01 << i});
        end
        $display("bit order test done");
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            d = $urandom;
            ext <= $urandom;
            acc(1, 8'hAC, r);
            acc(1, 8'hA8, d);
            pins(d & r, r);
            rd(8'hA8, {26'h0, (r & d) | (~r & ext)});
        end
        $display("direction test done");
        acc(1, 8'hAC, 8'hFF);
        acc(1, 8'hA8, 8'h5A);
        be <= 4'hE;
        acc(1, 8'hA8, 8'hA5);
        be <= 4'hF;
        rd(8'hA8, {26'h0, 8'h5A});
        pins(8'h5A, 8'hFF);
        rd(8'hB4, {2'h0, 32'h000000FF});
        $display("masked write test done");
        rd(8'h10, {GPD_RESP_DECERR, GPD_UNMAPPED});
        rd(8'hA9, {GPD_RESP_DECERR, GPD_UNMAPPED});
        $display("unmapped test done");
        wrap_up();
    end
endmodule
